/* File: design/tag_i2c_front_end.sv */
// Two-wire slave front end of a dual-port tag, with activity and
// harvesting outputs. Assumes i_clock far faster than the bus clock
// and an external memory that answers rd_data one cycle after request.
`timescale 1ns/1ns
`include "tag_front_end_defines.svh"

// Function
// - Match select code by 4-bit type identifier in upper bits.
// - Acknowledge the select byte when it matches.
// - Drive acknowledge in ninth clock period after each written byte.
// - Slave only; every bit moves with master serial clock.
// - Byte addressed serial port; memory also seen as 32-bit RF blocks.
// - Write-pending mode: output low during each RF internal write.
// - Command-active mode: output low while an RF command runs.
// - Activity output is open drain: pull low or release.
// - Activity output released unless main supply present.
// - Harvesting off and output high-Z when disabled or field weak.
// - Select byte MSB first: type, area bit, two ones, direction.
module tag_i2c_front_end
  import tag_front_end_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // Serial bus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  // Memory side
  output logic             o_wr_valid,
  output logic [15:0]      o_wr_addr,
  output logic [7:0]       o_wr_data,
  output logic             o_area_select_bit,
  output logic             o_rd_req,
  output logic [15:0]      o_rd_addr,
  input  wire logic [7:0]  i_rd_data,
  // RF core status and configuration
  input  wire logic        i_rf_write_active,
  input  wire logic        i_rf_cmd_active,
  input  wire logic        i_rf_command_active_mode,
  input  wire logic        i_vcc_present,
  output logic             o_rf_activity_output,
  output logic             o_rf_activity_output_oe,
  // Energy harvesting
  input  wire logic        i_harvest_enable,
  input  wire logic        i_field_ok,
  output logic             o_harvest_on,
  output logic             o_harvest_oe
);

  typedef struct packed {
    slave_state_e st;
    logic         scl_d;
    logic         sda_d;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic         rw;
    logic         area;
    logic [15:0]  addr;
    logic         sda_low;
    logic         wr_valid;
    logic [7:0]   wr_data;
    logic         rd_req;
    logic         rd_load;
    logic         act_low;
    logic         harvest;
  } front_s;

  front_s state_reg;
  front_s state_next;
  logic   scl_s;
  logic   sda_s;
  logic   scl_rise;
  logic   scl_fall;
  logic   start_seen;
  logic   stop_seen;
  logic   in_ack;

  pin_sync u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .o_scl   (scl_s),
    .o_sda   (sda_s)
  );

  // Select byte is type, area bit, two fixed ones, direction
  function automatic logic select_match(input logic [7:0] b);
    select_match = (b[7:4] == `DEV_TYPE_ID) &&
                   (b[2:1] == `DEV_FIXED_BITS);
  endfunction

  // ************************************************************
  // Bus events, sampled on synchronised levels
  // ************************************************************
  assign scl_rise   = scl_s & ~state_reg.scl_d;
  assign scl_fall   = ~scl_s & state_reg.scl_d;
  assign start_seen = scl_s & state_reg.scl_d & state_reg.sda_d & ~sda_s;
  assign stop_seen  = scl_s & state_reg.scl_d & ~state_reg.sda_d & sda_s;
  assign in_ack     = (state_reg.bit_cnt == `ACK_BIT_INDEX);

  // ************************************************************
  // Slave sequencer
  // ************************************************************
  always_comb begin
    state_next          = state_reg;
    state_next.scl_d    = scl_s;
    state_next.sda_d    = sda_s;
    state_next.wr_valid = 1'b0;
    state_next.rd_req   = 1'b0;
    if (start_seen) begin
      state_next.st      = st_select;
      // Clock fall that closes the start wraps this to zero
      state_next.bit_cnt = 4'hF;
      state_next.sda_low = 1'b0;
    end else if (stop_seen) begin
      state_next.st      = st_idle;
      state_next.sda_low = 1'b0;
    end else if (state_reg.st != st_idle && state_reg.st != st_ignore) begin
      // Read bytes move on the fall only, never on the rise
      if (scl_rise && !in_ack && state_reg.st != st_rdata) begin
        state_next.shift = {state_reg.shift[6:0], sda_s};
      end
      if (scl_rise && in_ack && state_reg.st == st_rdata && sda_s) begin
        // No-ack from master ends the read; wait for stop
        state_next.st = st_ignore;
      end
      if (scl_fall) begin
        if (in_ack) begin
          state_next.bit_cnt = 4'h0;
          state_next.sda_low = 1'b0;
          if (state_reg.st == st_rdata) begin
            state_next.sda_low = ~state_reg.shift[7];
          end
        end else if (state_reg.bit_cnt == `BYTE_BITS - 4'h1) begin
          state_next.bit_cnt = `ACK_BIT_INDEX;
          state_next.sda_low = 1'b0;
          case (state_reg.st)
            st_select: begin
              if (select_match(state_reg.shift)) begin
                state_next.sda_low = 1'b1;
                state_next.rw      = state_reg.shift[0];
                state_next.area    = state_reg.shift[3];
                state_next.st      = state_reg.shift[0] ? st_rdata
                                                        : st_addr_hi;
                state_next.rd_req  = state_reg.shift[0];
              end else begin
                state_next.st = st_ignore;
              end
            end
            st_addr_hi: begin
              state_next.addr[15:8] = state_reg.shift;
              state_next.sda_low    = 1'b1;
              state_next.st         = st_addr_lo;
            end
            st_addr_lo: begin
              state_next.addr[7:0] = state_reg.shift;
              state_next.sda_low   = 1'b1;
              state_next.st        = st_wdata;
            end
            st_wdata: begin
              state_next.wr_data  = state_reg.shift;
              state_next.wr_valid = 1'b1;
              state_next.addr     = state_reg.addr + 16'h0001;
              state_next.sda_low  = 1'b1;
            end
            st_rdata: begin
              // Release so the master can drive its ack bit
              state_next.addr   = state_reg.addr + 16'h0001;
              state_next.rd_req = 1'b1;
            end
            default: begin
              state_next.st = st_ignore;
            end
          endcase
        end else begin
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          if (state_reg.st == st_rdata) begin
            state_next.sda_low = ~state_reg.shift[6];
            state_next.shift   = {state_reg.shift[6:0], 1'b0};
          end
        end
      end
    end
    // Memory answers one cycle after the request pulse
    state_next.rd_load = state_reg.rd_req;
    // Load read byte; first bit goes out once ack slot ends
    if (state_reg.rd_load) begin
      state_next.shift = i_rd_data;
    end
    // ************************************************************
    // Activity and harvesting pins
    // ************************************************************
    state_next.act_low = i_vcc_present &&
                         (i_rf_command_active_mode ? i_rf_cmd_active
                                                   : i_rf_write_active);
    state_next.harvest = i_harvest_enable & i_field_ok;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg         <= '0;
      state_reg.st      <= st_idle;
      state_reg.scl_d   <= 1'b1;
      state_reg.sda_d   <= 1'b1;
      state_reg.addr    <= `ADDR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sda                   = 1'b0;
  assign o_sda_oe                = state_reg.sda_low;
  assign o_wr_valid              = state_reg.wr_valid;
  assign o_wr_addr               = state_reg.addr - 16'h0001;
  assign o_wr_data               = state_reg.wr_data;
  assign o_area_select_bit       = state_reg.area;
  assign o_rd_req                = state_reg.rd_req;
  assign o_rd_addr               = state_reg.addr;
  assign o_rf_activity_output    = 1'b0;
  assign o_rf_activity_output_oe = state_reg.act_low;
  assign o_harvest_on            = state_reg.harvest;
  assign o_harvest_oe            = state_reg.harvest;

endmodule

/* File: design/tag_front_end_defines.svh */
// Constants for the two-wire tag front end.
// Assumes inclusion by bare name from design files only.
`ifndef TAG_FRONT_END_DEFINES_SVH
`define TAG_FRONT_END_DEFINES_SVH

// Device type field, value arbitrary
`define DEV_TYPE_ID        4'h5
`define DEV_FIXED_BITS     2'h3
`define BYTE_BITS          4'h8
`define ACK_BIT_INDEX      4'h8
`define ADDR_RESET         16'h0000
`define MEM_BYTES          8192
`define RF_BLOCK_BITS      32

`endif

/* File: design/tag_front_end_pkg.sv */
// Types for the two-wire tag front end.
// Assumes nothing beyond a SystemVerilog compiler.
package tag_front_end_pkg;

  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_select  = 3'b001,
    st_addr_hi = 3'b010,
    st_addr_lo = 3'b011,
    st_wdata   = 3'b100,
    st_rdata   = 3'b101,
    st_ignore  = 3'b110
  } slave_state_e;

  typedef struct packed {
    logic [1:0] scl;
    logic [1:0] sda;
  } sync_s;

endpackage

/* File: design/pin_sync.sv */
// Two-flop synchronisers for the bus pins.
// Assumes pins are asynchronous to i_clock.
`timescale 1ns/1ns
module pin_sync
  import tag_front_end_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_srst,
  // Raw pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Synchronised levels
  output logic      o_scl,
  output logic      o_sda
);

  sync_s state_reg;
  sync_s state_next;

  always_comb begin
    state_next     = state_reg;
    // Idle bus reads high
    state_next.scl = {state_reg.scl[0], i_scl};
    state_next.sda = {state_reg.sda[0], i_sda};
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '{scl: 2'h3, sda: 2'h3};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_scl = state_reg.scl[1];
  assign o_sda = state_reg.sda[1];

endmodule

/* File: bench/tag_props.sv */
// Checker for the tag front end outputs.
// Assumes a bind to tag_i2c_front_end, ports watched by name.
`timescale 1ns/1ns
module tag_props (
  // Clock, reset and bus
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_wr_valid,
  // Activity and harvest
  input wire logic i_rf_write_active,
  input wire logic i_rf_cmd_active,
  input wire logic i_rf_command_active_mode,
  input wire logic i_vcc_present,
  input wire logic o_rf_activity_output,
  input wire logic o_rf_activity_output_oe,
  input wire logic i_harvest_enable,
  input wire logic i_field_ok,
  input wire logic o_harvest_on,
  input wire logic o_harvest_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // ****
  // Properties
  // ****
  property p_open_drain;
    o_rf_activity_output == 1'h0 && o_sda == 1'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin drives high");
  property p_supply;
    !i_srst && !i_vcc_present |=> !o_rf_activity_output_oe;
  endproperty
  a_supply: assert property (p_supply) else $error("activity without supply");
  // Reset in antecedent keeps $past off reset-time inputs
  property p_busy;
    !i_srst && i_vcc_present && i_rf_command_active_mode
      |=> o_rf_activity_output_oe == $past(i_rf_cmd_active);
  endproperty
  a_busy: assert property (p_busy) else $error("busy mode mismatch");
  property p_wip;
    !i_srst && i_vcc_present && !i_rf_command_active_mode
      |=> o_rf_activity_output_oe == $past(i_rf_write_active);
  endproperty
  a_wip: assert property (p_wip) else $error("write mode mismatch");
  property p_harvest;
    !i_srst |=> o_harvest_on == $past(i_harvest_enable && i_field_ok)
      && o_harvest_oe == o_harvest_on;
  endproperty
  a_harvest: assert property (p_harvest) else $error("harvest mismatch");
  property p_ack;
    o_wr_valid |-> ##[0:8] o_sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("written byte not acked");
  property p_rise_low;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_rise_low: assert property (p_rise_low) else $error("data moved, clock high");
  property p_fall_low;
    $fell(o_sda_oe) |-> !i_scl;
  endproperty
  a_fall_low: assert property (p_fall_low) else $error("ack cut short");
endmodule

bind tag_i2c_front_end tag_props tag_props_i (
  .i_clock                 (i_clock),
  .i_srst                  (i_srst),
  .i_scl                   (i_scl),
  .o_sda                   (o_sda),
  .o_sda_oe                (o_sda_oe),
  .o_wr_valid              (o_wr_valid),
  .i_rf_write_active       (i_rf_write_active),
  .i_rf_cmd_active         (i_rf_cmd_active),
  .i_rf_command_active_mode(i_rf_command_active_mode),
  .i_vcc_present           (i_vcc_present),
  .o_rf_activity_output    (o_rf_activity_output),
  .o_rf_activity_output_oe (o_rf_activity_output_oe),
  .i_harvest_enable        (i_harvest_enable),
  .i_field_ok              (i_field_ok),
  .o_harvest_on            (o_harvest_on),
  .o_harvest_oe            (o_harvest_oe)
);

/* File: bench/bus_master_model.sv */
// Two-wire bus master model for the tag front end.
// Assumes a pull-up on the data line and a running i_clock.
`timescale 1ns/1ns
module bus_master_model (
  // Clock and slave pull
  input  wire logic i_clock,
  input  wire logic i_sda_oe,
  // Bus lines
  output logic      o_scl,
  output logic      o_sda
);
  logic drive = 1'h1;
  logic scl_q = 1'h1;
  assign o_scl = scl_q;
  // Pull-up: low only while some party pulls
  assign o_sda = drive & ~i_sda_oe;
  // ****
  // Bus tasks
  // ****
  task automatic half();
    repeat (8) @(posedge i_clock);
  endtask
  task automatic start();
    half();
    drive <= 1'h1;
    half();
    scl_q <= 1'h1;
    half();
    drive <= 1'h0;
    half();
    scl_q <= 1'h0;
  endtask
  task automatic stop();
    half();
    drive <= 1'h0;
    half();
    scl_q <= 1'h1;
    half();
    drive <= 1'h1;
    half();
  endtask
  // Data moves only while clock low
  task automatic bitx(input logic b, output logic s);
    half();
    drive <= b;
    half();
    scl_q <= 1'h1;
    half();
    s = o_sda;
    scl_q <= 1'h0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) bitx(b[k], s);
    bitx(1'h1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bitx(1'h1, s);
      b[k] = s;
    end
    bitx(~ack, s);
  endtask
endmodule

/* File: bench/dual_port_tag_i2c_front_end_bench.sv */
// Self-checking bench for the tag front end.
// Assumes the bus master model and a memory answering in one cycle.
`timescale 1ns/1ns
module dual_port_tag_i2c_front_end_bench;
  logic        i_clock = 1'h0;
  logic        i_srst = 1'h1;
  logic        i_scl, i_sda, o_sda, o_sda_oe, o_wr_valid, o_area_select_bit;
  logic        o_rd_req, o_rf_activity_output, o_rf_activity_output_oe;
  logic        o_harvest_on, o_harvest_oe;
  logic [15:0] o_wr_addr, o_rd_addr, seen_addr, acks = 16'h0;
  logic [7:0]  o_wr_data, seen_data, i_rd_data = 8'h00;
  logic        i_rf_write_active = 1'h0, i_rf_cmd_active = 1'h0;
  logic        i_rf_command_active_mode = 1'h0, i_vcc_present = 1'h0;
  logic        i_harvest_enable = 1'h0, i_field_ok = 1'h0;
  logic [7:0]  rows [6] = '{8'hEF, 8'hD8, 8'h96, 8'hAD, 8'h70, 8'h3D};
  int          errors = 0;
  int          comparisons = 0;
  always #20 i_clock = ~i_clock;
  tag_i2c_front_end tag_i2c_front_end_i (
    .i_clock                 (i_clock),
    .i_srst                  (i_srst),
    .i_scl                   (i_scl),
    .i_sda                   (i_sda),
    .o_sda                   (o_sda),
    .o_sda_oe                (o_sda_oe),
    .o_wr_valid              (o_wr_valid),
    .o_wr_addr               (o_wr_addr),
    .o_wr_data               (o_wr_data),
    .o_area_select_bit       (o_area_select_bit),
    .o_rd_req                (o_rd_req),
    .o_rd_addr               (o_rd_addr),
    .i_rd_data               (i_rd_data),
    .i_rf_write_active       (i_rf_write_active),
    .i_rf_cmd_active         (i_rf_cmd_active),
    .i_rf_command_active_mode(i_rf_command_active_mode),
    .i_vcc_present           (i_vcc_present),
    .o_rf_activity_output    (o_rf_activity_output),
    .o_rf_activity_output_oe (o_rf_activity_output_oe),
    .i_harvest_enable        (i_harvest_enable),
    .i_field_ok              (i_field_ok),
    .o_harvest_on            (o_harvest_on),
    .o_harvest_oe            (o_harvest_oe)
  );
  bus_master_model bus_master_model_i (.i_clock, .i_sda_oe(o_sda_oe),
    .o_scl(i_scl), .o_sda(i_sda));
  // Memory pattern lets reads be predicted from the address alone
  always @(posedge i_clock) begin
    if (o_rd_req) i_rd_data <= o_rd_addr[7:0] ^ 8'h3C;
    if (o_wr_valid) {seen_addr, seen_data} <= {o_wr_addr, o_wr_data};
  end
  // ****
  // Helpers
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] b);
    logic a;
    bus_master_model_i.send(b, a);
    acks = {acks[14:0], a};
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    logic [7:0] d1, d2;
    repeat (20) @(posedge i_clock);
    i_srst <= 1'h0;
    #1 check({13'h0, o_rf_activity_output_oe, o_harvest_on, o_sda_oe},
      16'h0);
    for (int r = 0; r < 6; r++) begin
      @(posedge i_clock);
      {i_vcc_present, i_rf_command_active_mode, i_rf_cmd_active,
        i_rf_write_active, i_harvest_enable, i_field_ok} <= rows[r][7:2];
      repeat (3) @(posedge i_clock);
      #1 check({12'h0, o_rf_activity_output, o_rf_activity_output_oe,
        o_harvest_on, o_harvest_oe},
        {13'h0, rows[r][1], {2{rows[r][0]}}});
    end
    bus_master_model_i.start();
    put(8'h5E);
    put(8'h12);
    put(8'h34);
    put(8'hA5);
    check({seen_addr[7:0], seen_data}, 16'h34A5);
    put(8'h5A);
    check({o_area_select_bit, seen_addr[6:0], seen_data}, 16'hB55A);
    bus_master_model_i.stop();
    // Random read: repeated start right after the address
    bus_master_model_i.start();
    put(8'h56);
    put(8'h20);
    put(8'h00);
    bus_master_model_i.start();
    put(8'h57);
    check({15'h0, o_area_select_bit}, 16'h0000);
    bus_master_model_i.recv(1'h1, d1);
    bus_master_model_i.recv(1'h0, d2);
    bus_master_model_i.stop();
    check({d1, d2}, 16'h3C3D);
    bus_master_model_i.start();
    put(8'h3E);
    bus_master_model_i.stop();
    bus_master_model_i.start();
    put(8'h5A);
    bus_master_model_i.stop();
    check(acks, 16'h07FC);
    wrap_up();
  end
  initial begin
    #800000;
    errors++;
    wrap_up();
  end
endmodule
